// file: hw/led_scan_pkg.sv
package led_scan_pkg;

    // Core interface widths
    localparam int NIBBLE_W     = 4;
    localparam int ROW_W        = 2;
    localparam int COL_W        = 4;
    localparam int SEG_W        = 8;
    localparam int DIGIT_W      = 6;
    localparam int XDIGIT_W     = 2;
    localparam int DIGIT_IDX_W  = 3;
    localparam int RAM_ROWS     = 3;
    localparam int RAM_COLS     = 16;

    // Column pointer value that addresses the mode register
    localparam logic [COL_W-1:0] MODE_SELECT_COL = 4'hB;

    // Mode register field positions
    localparam int BUFFER_ROW_SELECT_BIT = 3;
    localparam int STROBE_SELECT_BIT     = 2;
    localparam int DIGIT_COUNT_HI_BIT    = 1;
    localparam int DIGIT_COUNT_LO_BIT    = 0;
    localparam logic [NIBBLE_W-1:0] MODE_RESET_VAL = 4'h0;

    // Explicit mode codes
    localparam logic [NIBBLE_W-1:0] MODE_ALL_OFF   = 4'h0;
    localparam logic [NIBBLE_W-1:0] MODE_LATCH_ROW0 = 4'h1;
    localparam logic [NIBBLE_W-1:0] MODE_LATCH_ROW2 = 4'h9;

    // Buffer rows and latched output columns
    localparam logic [ROW_W-1:0] ROW_BUF0     = 2'h0;
    localparam logic [ROW_W-1:0] ROW_BUF2     = 2'h2;
    localparam logic [COL_W-1:0] COL_LATCH_LO = 4'hE;
    localparam logic [COL_W-1:0] COL_LATCH_HI = 4'hF;

    // Last digit index per digit count code 00,01,10,11
    localparam logic [DIGIT_IDX_W-1:0] LAST_DIGIT_4 = 3'h3;
    localparam logic [DIGIT_IDX_W-1:0] LAST_DIGIT_5 = 3'h4;
    localparam logic [DIGIT_IDX_W-1:0] LAST_DIGIT_6 = 3'h5;
    localparam logic [DIGIT_IDX_W-1:0] LAST_DIGIT_8 = 3'h7;

    // Digit dwell time in machine cycles
    localparam int DIGIT_MACHINE_CYCLES = 13;

    // Segment idle level (common anode: high = segment off)
    localparam logic [SEG_W-1:0] SEG_IDLE = 8'hFF;

    // Core write request to the mode register
    typedef struct packed {
        logic                valid;
        logic [COL_W-1:0]    col_ptr;
        logic [NIBBLE_W-1:0] acc;
    } port_write_t;

    // Outward display pins
    typedef struct packed {
        logic [SEG_W-1:0]    segment_port;
        logic [DIGIT_W-1:0]  digit_port;
        logic [XDIGIT_W-1:0] extra_digit_lines;
        logic                extra_digit_en;
    } display_pins_t;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_LATCH,
        MODE_SCAN
    } disp_mode_t;

endpackage

// file: hw/digit_dwell_timer.sv
module digit_dwell_timer
    import led_scan_pkg::*;
#(
    parameter int DWELL = DIGIT_MACHINE_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic machine_cycle,
    input  wire logic restart,
    output logic      dwell_done
);

    typedef struct packed {
        logic [7:0] count;
    } timer_state_t;

    localparam logic [7:0] LAST = 8'(DWELL - 1);

    timer_state_t state_reg;
    timer_state_t state_next;

    // Counts machine cycles spent on one digit
    always_comb begin
        state_next = state_reg;
        dwell_done = 1'b0;
        if (restart) begin
            state_next.count = 8'h00;
        end else if (machine_cycle) begin
            if (state_reg.count == LAST) begin
                state_next.count = 8'h00;
                dwell_done = 1'b1;
            end else begin
                state_next.count = state_reg.count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// file: hw/led_display_scan_controller.sv
// What this block does
// - Segment port drives cathodes, digit port drives anodes directly.
// - Six direct digit lines, two more via port 4 low bits.
// - Digit lines 4 and 5 follow aux port bits when unused.
// - Decoder picks digit; RAM pair goes to segments; digit enabled.
// - After 13 machine cycles: digit off, advance, repeat.
// - Scanning needs no program help; buffer changes show next scan.
// - Mode register loads from accumulator on port write with column B.
// - New mode takes effect at once; any code 0 to F accepted.
// - Code 0001: latch 0EH low nibble, 0FH high, digits 0-3 off.
// - Code 1001: latch 2EH low nibble, 2FH high, digits 0-3 off.
// - Top bit picks row 0 or 2; next bit picks scan, else latch (codes 0001, 1001) or all-off.
// - Row 2 scans use 20H onward.
// - RAM is three rows of sixteen nibbles.
module led_display_scan_controller
    import led_scan_pkg::*;
#(
    parameter int CLK_PER_MACHINE_CYCLE = 1000,
    parameter int DWELL                 = DIGIT_MACHINE_CYCLES
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  led_scan_pkg::port_write_t           output_to_port_instr,
    input  wire logic                           ram_we,
    input  wire logic [led_scan_pkg::ROW_W-1:0] ram_row,
    input  wire logic [led_scan_pkg::COL_W-1:0] ram_col,
    input  wire logic [led_scan_pkg::NIBBLE_W-1:0] ram_wdata,
    output logic [led_scan_pkg::NIBBLE_W-1:0]   ram_rdata,
    input  wire logic [led_scan_pkg::XDIGIT_W-1:0] port4_low_bits,
    input  wire logic [led_scan_pkg::XDIGIT_W-1:0] aux_output_bits,
    output led_scan_pkg::display_pins_t         display_pins
);
    import led_scan_pkg::*;

    localparam int DIV_W = $clog2(CLK_PER_MACHINE_CYCLE + 1);
    localparam logic [DIV_W-1:0] DIV_LAST =
        DIV_W'(CLK_PER_MACHINE_CYCLE - 1);

    typedef struct packed {
        logic [NIBBLE_W-1:0]    mode;
        logic [DIV_W-1:0]       div;
        logic [DIGIT_IDX_W-1:0] digit;
        logic [SEG_W-1:0]       seg;
        logic [DIGIT_W-1:0]     dig;
        logic [XDIGIT_W-1:0]    xdig;
        logic                   xdig_en;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    // Display RAM, three rows of sixteen nibbles
    logic [NIBBLE_W-1:0] ram [RAM_ROWS*RAM_COLS];

    logic       machine_cycle;
    logic       dwell_done;
    logic       mode_write;
    disp_mode_t disp_mode;
    logic [ROW_W-1:0] buf_row;
    logic [DIGIT_IDX_W-1:0] last_digit;
    logic [SEG_W-1:0] seg_src;

    function automatic int ram_index(input logic [ROW_W-1:0] r,
                                     input logic [COL_W-1:0] c);
        return int'(r) * RAM_COLS + int'(c);
    endfunction

    // Classifies a mode code; unused codes fall back to all-off
    function automatic disp_mode_t decode_mode(input logic [NIBBLE_W-1:0] m);
        if (m[STROBE_SELECT_BIT]) begin
            return MODE_SCAN;
        end else if (m == MODE_LATCH_ROW0 || m == MODE_LATCH_ROW2) begin
            return MODE_LATCH;
        end else begin
            return MODE_OFF;
        end
    endfunction

    // Core side access to the RAM; rows past 2 are not populated
    always_ff @(posedge clk_sys) begin
        if (ram_we && ram_row < ROW_W'(RAM_ROWS)) begin
            ram[ram_index(ram_row, ram_col)] <= ram_wdata;
        end
    end

    always_comb begin
        if (ram_row < ROW_W'(RAM_ROWS)) begin
            ram_rdata = ram[ram_index(ram_row, ram_col)];
        end else begin
            ram_rdata = '0;
        end
    end

    // Decode of the live mode
    always_comb begin
        disp_mode = decode_mode(state_reg.mode);
        buf_row = state_reg.mode[BUFFER_ROW_SELECT_BIT] ?
                  ROW_BUF2 : ROW_BUF0;
        unique case ({state_reg.mode[DIGIT_COUNT_HI_BIT],
                      state_reg.mode[DIGIT_COUNT_LO_BIT]})
            2'b00: last_digit = LAST_DIGIT_4;
            2'b01: last_digit = LAST_DIGIT_5;
            2'b10: last_digit = LAST_DIGIT_6;
            2'b11: last_digit = LAST_DIGIT_8;
        endcase
    end

    // Port write addressed to the mode register
    assign mode_write = output_to_port_instr.valid &&
                        output_to_port_instr.col_ptr == MODE_SELECT_COL;

    // Segment source: digit pair in scan, fixed pair in latch mode
    always_comb begin
        if (disp_mode == MODE_LATCH) begin
            seg_src = {ram[ram_index(buf_row, COL_LATCH_HI)],
                       ram[ram_index(buf_row, COL_LATCH_LO)]};
        end else begin
            seg_src = {ram[ram_index(buf_row,
                           {state_reg.digit, 1'b1})],
                       ram[ram_index(buf_row,
                           {state_reg.digit, 1'b0})]};
        end
    end

    // Machine-cycle enable for the dwell counter
    assign machine_cycle = (state_reg.div == DIV_LAST);

    digit_dwell_timer #(
        .DWELL (DWELL)
    ) u_dwell (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .machine_cycle (machine_cycle),
        .restart       (mode_write),
        .dwell_done    (dwell_done)
    );

    // Main update: mode load, scan step and output latches
    always_comb begin
        state_next = state_reg;
        state_next.div = machine_cycle ? '0 : state_reg.div + DIV_W'(1);
        if (mode_write) begin
            state_next.mode  = output_to_port_instr.acc;
            state_next.digit = '0;
        end else if (dwell_done && disp_mode == MODE_SCAN) begin
            // Wrap at the scan length chosen by the low bits
            state_next.digit = (state_reg.digit >= last_digit) ?
                               '0 : state_reg.digit + 3'h1;
        end
        // Scan digit beyond the count cannot persist after a mode change
        if (!mode_write && state_reg.digit > last_digit) begin
            state_next.digit = '0;
        end

        // Outputs; one cycle of latency through the output latches
        state_next.seg     = SEG_IDLE;
        state_next.dig     = '0;
        state_next.xdig    = port4_low_bits;
        state_next.xdig_en = 1'b0;
        unique case (disp_mode)
            MODE_OFF: begin
                state_next.seg = SEG_IDLE;
                state_next.dig = '0;
                state_next.dig[5:4] = aux_output_bits;
            end
            MODE_LATCH: begin
                state_next.seg = seg_src;
                state_next.dig[5:4] = aux_output_bits;
            end
            MODE_SCAN: begin
                state_next.seg = seg_src;
                if (dwell_done) begin
                    state_next.dig = '0;
                end else if (state_reg.digit < 3'h6) begin
                    state_next.dig[state_reg.digit] = 1'b1;
                end else begin
                    state_next.xdig_en = 1'b1;
                    state_next.xdig = '0;
                    state_next.xdig[state_reg.digit[0]] = 1'b1;
                end
                if (last_digit < LAST_DIGIT_6) begin
                    state_next.dig[5] = aux_output_bits[1];
                end
                if (last_digit < LAST_DIGIT_5) begin
                    state_next.dig[4] = aux_output_bits[0];
                end
            end
        endcase
    end

    // State register; mode comes up all-off
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg      <= '0;
            state_reg.mode <= MODE_RESET_VAL;
            state_reg.seg  <= SEG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pins come straight from the output latches
    assign display_pins.segment_port      = state_reg.seg;
    assign display_pins.digit_port        = state_reg.dig;
    assign display_pins.extra_digit_lines = state_reg.xdig;
    assign display_pins.extra_digit_en    = state_reg.xdig_en;

endmodule

// file: verif/led_scan_props.sv
module led_scan_props
    import led_scan_pkg::*;
#(
    parameter int CLK_PER_MACHINE_CYCLE = 1000,
    parameter int DWELL                 = DIGIT_MACHINE_CYCLES
) (
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input led_scan_pkg::port_write_t  output_to_port_instr,
    input wire logic                  ram_we,
    input wire logic [1:0]            ram_row,
    input wire logic [3:0]            ram_col,
    input wire logic [3:0]            ram_wdata,
    input wire logic [3:0]            ram_rdata,
    input wire logic [1:0]            port4_low_bits,
    input wire logic [1:0]            aux_output_bits,
    input led_scan_pkg::display_pins_t display_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  mem [0:2][0:15];
    logic [3:0]  mode_reg, pin_mode_reg;
    logic [1:0]  aux_reg, p4_reg;
    logic [7:0]  lv_reg;
    logic [15:0] lit_reg;
    logic [5:0]  dp;
    logic        off_m, latch_m;
    logic        mode_wr_m;

    // Shadow RAM; row 3 is absent
    always_ff @(posedge clk_sys) begin
        if (ram_we && ram_row != 2'h3) begin
            mem[ram_row][ram_col] <= ram_wdata;
        end
    end
    // Pins lag the mode register by one clock, so track both
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_reg <= 4'h0;
            pin_mode_reg <= 4'h0;
            lit_reg <= 16'h0;
        end else begin
            if (mode_wr_m) begin
                mode_reg <= output_to_port_instr.acc;
            end
            pin_mode_reg <= mode_reg;
            // A mode write restarts the dwell, so the lit count restarts
            lit_reg <= (dp[0] && !mode_wr_m) ? lit_reg + 16'h1 : 16'h0;
        end
    end
    // Registered copies of what the pins should carry next
    always_ff @(posedge clk_sys) begin
        aux_reg <= aux_output_bits;
        p4_reg <= port4_low_bits;
        lv_reg <= {mem[{mode_reg[3], 1'b0}][15], mem[{mode_reg[3], 1'b0}][14]};
    end
    assign dp = display_pins.digit_port;
    assign mode_wr_m = output_to_port_instr.valid
        && output_to_port_instr.col_ptr == MODE_SELECT_COL;
    assign off_m = pin_mode_reg inside {4'h0, 4'h2, 4'h3, 4'h8, 4'hA, 4'hB};
    assign latch_m = pin_mode_reg[2:0] == 3'h1;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_one_digit: assert property ($onehot0(dp[3:0]))
        else $error("two digit lines lit at once");
    chk_off_mode: assert property (off_m |->
        display_pins.segment_port == SEG_IDLE && dp[3:0] == 4'h0)
        else $error("off mode not blank");
    chk_latch_seg: assert property (latch_m |->
        display_pins.segment_port == lv_reg)
        else $error("latched output wrong");
    chk_latch_dig: assert property (latch_m |-> dp[3:0] == 4'h0)
        else $error("digit lit in latch mode");
    chk_aux_pass: assert property ((off_m || latch_m) |-> dp[5:4] == aux_reg)
        else $error("aux bits not on digit lines 4 and 5");
    chk_extra_en: assert property (display_pins.extra_digit_en |->
        pin_mode_reg[2:0] == 3'h7)
        else $error("extra digits outside 8 digit scan");
    chk_port4_pass: assert property (!display_pins.extra_digit_en |->
        display_pins.extra_digit_lines == p4_reg)
        else $error("port 4 bits not passed");
    chk_dwell_max: assert property (
        lit_reg <= 16'(DWELL * CLK_PER_MACHINE_CYCLE))
        else $error("digit lit too long");
    chk_dwell_min: assert property ($fell(dp[0]) && pin_mode_reg[2] |->
        lit_reg >= 16'((DWELL - 1) * CLK_PER_MACHINE_CYCLE))
        else $error("digit lit too briefly");
    chk_aux_scan: assert property (pin_mode_reg[2:1] == 2'h2 |->
        dp[5] == aux_reg[1] && (pin_mode_reg[0] || dp[4] == aux_reg[0]))
        else $error("aux bits lost in short scan");
    chk_ram_rdback: assert property (ram_we && ram_row != 2'h3 ##1
        $stable({ram_row, ram_col}) |-> ram_rdata == $past(ram_wdata))
        else $error("ram read back wrong");
    chk_row3_zero: assert property (ram_row == 2'h3 |-> ram_rdata == 4'h0)
        else $error("row 3 reads nonzero");
    cover property (display_pins.extra_digit_en);
    cover property (latch_m && pin_mode_reg[3]);
    cover property ($fell(dp[0]) && pin_mode_reg == 4'h4);
endmodule

bind led_display_scan_controller led_scan_props #(
    .CLK_PER_MACHINE_CYCLE(CLK_PER_MACHINE_CYCLE),
    .DWELL(DWELL)
) led_scan_props_i (.clk_sys(clk_sys), .rst(rst),
    .output_to_port_instr(output_to_port_instr), .ram_we(ram_we),
    .ram_row(ram_row), .ram_col(ram_col), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .port4_low_bits(port4_low_bits),
    .aux_output_bits(aux_output_bits), .display_pins(display_pins));

// file: verif/led_panel_model.sv
module led_panel_model
    import led_scan_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   clear,
    input led_scan_pkg::display_pins_t display_pins,
    output logic [7:0]                 seen,
    output logic [7:0]                 shown [8]
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lit;

    // Anode high lights a digit; extra pair stands for digits 6 and 7
    assign lit = {display_pins.extra_digit_en
        ? display_pins.extra_digit_lines : 2'h0, display_pins.digit_port};
    // A lit digit shows its cathode pattern, low segment glows
    always @(posedge clk_sys) begin
        for (int d = 0; d < 8; d++) begin
            if (clear) begin
                seen[d] <= 1'b0;
            end else if (lit[d]) begin
                seen[d] <= 1'b1;
                shown[d] <= display_pins.segment_port;
            end
        end
    end
endmodule

// file: verif/tb_top.sv
module tb_top
    import led_scan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPM = 2;
    localparam int DW = 13;
    logic clk_sys, rst, ram_we, clear;
    logic [1:0] ram_row, p4, aux;
    logic [3:0] ram_col, ram_wdata, ram_rdata;
    logic [7:0] seen;
    logic [7:0] shown [8];
    logic [3:0] exp_mem [0:2][0:15];
    port_write_t opi;
    display_pins_t pins;
    int seed = 29;
    int fail_count = 0;
    int check_count = 0;

    led_display_scan_controller #(.CLK_PER_MACHINE_CYCLE(CPM), .DWELL(DW))
    led_display_scan_controller_i (.clk_sys(clk_sys), .rst(rst),
        .output_to_port_instr(opi), .ram_we(ram_we), .ram_row(ram_row),
        .ram_col(ram_col), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .port4_low_bits(p4), .aux_output_bits(aux), .display_pins(pins));
    led_panel_model led_panel_model_i (.clk_sys(clk_sys), .clear(clear),
        .display_pins(pins), .seen(seen), .shown(shown));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Address stays put after the strobe so read-back is possible
    task automatic ram_wr(input logic [1:0] r, input logic [3:0] c, d);
        @(negedge clk_sys);
        ram_we = 1'b1;
        ram_row = r;
        ram_col = c;
        ram_wdata = d;
        if (r != 2'h3) exp_mem[r][c] = d;
        @(negedge clk_sys);
        ram_we = 1'b0;
    endtask
    // One-cycle port write, then two edges for the pins to follow
    task automatic mode_wr(input logic [3:0] a, input logic [3:0] c);
        @(negedge clk_sys);
        opi = '{valid: 1'b1, col_ptr: c, acc: a};
        @(negedge clk_sys);
        opi.valid = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    function automatic int digits(input logic [3:0] m);
        return (m[1:0] == 2'h3) ? 8 : 4 + m[1:0];
    endfunction
    function automatic logic [7:0] seg_of(input int r, input int d);
        return {exp_mem[r][2*d+1], exp_mem[r][2*d]};
    endfunction
    // Watch one full scan and compare what each digit showed
    task automatic scan_chk(input logic [3:0] m);
        int n;
        logic [7:0] mask;
        n = digits(m);
        mask = 8'((1 << n) - 1);
        clear = 1'b1;
        @(negedge clk_sys);
        clear = 1'b0;
        repeat (n * (DW * CPM + 2) + 4) @(negedge clk_sys);
        // Lines 4 and 5 outside a short scan carry the aux levels
        cmp(seen, mask | ({2'h0, aux, 4'h0} & ~mask));
        for (int d = 0; d < n; d++) cmp(shown[d], seg_of(m[3] ? 2 : 0, d));
    endtask

    initial begin
        rst = 1'b1;
        opi = '0;
        {ram_we, ram_row, ram_col, ram_wdata, p4, aux, clear} = '0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 48; i++) begin
            ram_wr(2'(i / 16), 4'(i % 16), 4'($random(seed)));
            cmp(8'(ram_rdata), 8'(exp_mem[i / 16][i % 16]));
        end
        ram_wr(2'h3, 4'h5, 4'hA);
        cmp(8'(ram_rdata), 8'h00);
        // Every mode code, with random levels on the pass-through ports
        for (int m = 0; m < 16; m++) begin
            aux = 2'($random(seed));
            p4 = 2'($random(seed));
            mode_wr(4'(m), MODE_SELECT_COL);
            if (m[2]) begin
                scan_chk(4'(m));
            end else begin
                cmp(pins.segment_port, (m[1:0] == 2'h1)
                    ? seg_of(m[3] ? 2 : 0, 7) : SEG_IDLE);
                cmp(8'(pins.digit_port), {2'h0, aux, 4'h0});
                cmp(8'(pins.extra_digit_lines), 8'(p4));
            end
        end
        // Buffer change mid-scan and an ignored port write
        mode_wr(4'h4, MODE_SELECT_COL);
        ram_wr(2'h0, 4'h3, 4'($random(seed)));
        mode_wr(4'h0, 4'hA);
        scan_chk(4'h4);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        stop_test();
    end
endmodule
